// ---- verilog/tape_load_mode_sequencer.sv ----
// tape load and 24-bit word input sequencer with avalon register slave
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "tlms_consts.svh"
module tape_load_mode_sequencer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // tape reader link
  input  wire logic [6:0]  frame_in,
  input  wire logic        input_resume,
  input  wire logic        ext_disconnect,
  output logic             input_enable,
  // storage write port and instruction fetch request
  output tlms_pkg::mem_req_t mem_req,
  output logic             next_instr
);
  localparam int FIN = `FINAL_EN_CYCLES;

  tlms_pkg::state_t state;        // sequencer state
  logic [6:0]       in_reg;       // input register
  logic [23:0]      xch;          // exchange register
  logic [23:0]      asm_q;        // assembly register
  logic [23:0]      acc;          // accumulator for address check
  logic [14:0]      addr_u;       // storage address register
  logic [14:0]      prog_p;       // program address register
  logic [4:0]       seq;          // sequence register stages
  logic             ie;           // input enable flag
  logic             itx;          // input to exchange flag
  logic             ir;           // input resume flag
  logic             rpt;          // repeat sequence flag
  logic             in_fault;     // double resume fault
  logic             chk_fault;    // load check fault
  logic [8:0]       fin_cnt;      // truncated enable countdown
  logic             ctrl_load;    // load mode switch level
  logic [2:0]       m_sel;        // word assembly selector
  logic [6:0]       frame_s;      // synchronised frame
  logic             resume_s;     // synchronised resume
  logic             disc_s;       // synchronised disconnect
  logic             resume_d;     // resume last cycle
  logic             disc_d;       // disconnect last cycle
  logic [31:0]      rd_mux;       // read data selection

  // decode helper shared by every register access
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // link inputs into the clock domain
  tlms_sync3 #(.W(9)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({ext_disconnect, input_resume, frame_in}),
    .clean    ({disc_s, resume_s, frame_s})
  );

  // bus strobes and link events
  logic bus_we;      // write takes effect this edge
  logic ctrl_wr;     // write to control, lane 0
  logic load_edge;   // switch moved into load mode
  logic load_exit;   // switch moved out of load mode
  logic start_cmd;   // start word input instruction
  logic resume_edge; // new frame offered
  logic disc_edge;   // disconnect raised
  logic step;        // frame being assembled
  logic act_rec;     // record or word complete
  logic rec_insert;  // insert address record
  logic rec_check;   // check address record
  logic chk_zero;    // address check matched
  logic dbl_resume;  // resume while unsampled frame waits
  logic active;      // sequencer busy

  assign bus_we      = avs_write && !avs_waitrequest;
  assign ctrl_wr     = bus_we && hit(avs_address, `REG_CTRL)
                       && avs_byteenable[0];
  assign load_edge   = ctrl_wr && avs_writedata[`CTRL_LOAD_BIT] && !ctrl_load;
  assign load_exit   = ctrl_wr && !avs_writedata[`CTRL_LOAD_BIT] && ctrl_load;
  assign start_cmd   = ctrl_wr && avs_writedata[`CTRL_START_BIT] && !ctrl_load
                       && !avs_writedata[`CTRL_LOAD_BIT]
                       && (state == tlms_pkg::S_IDLE
                           || state == tlms_pkg::S_HALT)
                       && (avs_writedata[`CTRL_M_MSB:`CTRL_M_LSB] == `M_FULL
                        || avs_writedata[`CTRL_M_MSB:`CTRL_M_LSB] == `M_LOW15);
  assign resume_edge = resume_s && !resume_d;
  assign disc_edge   = disc_s && !disc_d;
  assign step        = (state == tlms_pkg::S_STEP);
  assign act_rec     = (state == tlms_pkg::S_ACT) && seq[`C_MARK];
  assign rec_insert  = act_rec && ctrl_load && seq[`C_A];
  assign rec_check   = act_rec && ctrl_load && !seq[`C_A]
                       && seq[`C_B];
  assign chk_zero    = (acc == {9'h000, addr_u});
  assign active      = (state != tlms_pkg::S_IDLE)
                       && (state != tlms_pkg::S_HALT);
  assign dbl_resume  = active && resume_edge && ir && !step;

  // sequence register
  tlms_seq_reg u_seq (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clr_all    (load_edge),
    .preset     (state == tlms_pkg::S_CLRQ && !ctrl_load),
    .clr_marker (act_rec),
    .shift      (step),
    .load_mode  (ctrl_load),
    .ctrl_bit   (in_reg[6]),
    .seq        (seq)
  );

  // edge memories for link events
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resume_d <= 1'b0;
      disc_d   <= 1'b0;
    end else begin
      resume_d <= resume_s;
      disc_d   <= disc_s;
    end
  end

  // control register: switch, selector, repeat
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_load <= 1'b0;
      m_sel     <= `M_FULL;
      rpt       <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_load <= avs_writedata[`CTRL_LOAD_BIT];
      end
      if (start_cmd) begin
        m_sel <= avs_writedata[`CTRL_M_MSB:`CTRL_M_LSB];
        rpt   <= avs_writedata[`CTRL_RPT_BIT];
      end else if (disc_edge || load_edge) begin
        rpt <= 1'b0;
      end
    end
  end

  // sequencer state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= tlms_pkg::S_IDLE;
    end else if (load_edge) begin
      state <= tlms_pkg::S_CLRQ;
    end else if (load_exit) begin
      state <= tlms_pkg::S_IDLE;
    end else if (disc_edge && active) begin
      state <= tlms_pkg::S_IDLE;
    end else if (dbl_resume) begin
      state <= tlms_pkg::S_HALT;
    end else begin
      unique case (state)
        tlms_pkg::S_IDLE: begin
          if (start_cmd) state <= tlms_pkg::S_CLRQ;
        end
        tlms_pkg::S_CLRQ: begin
          state <= tlms_pkg::S_WAIT;
        end
        tlms_pkg::S_WAIT: begin
          // hold until a frame stands ready
          if (itx && ir) state <= tlms_pkg::S_STEP;
        end
        tlms_pkg::S_STEP: begin
          state <= tlms_pkg::S_ACT;
        end
        tlms_pkg::S_ACT: begin
          if (!seq[`C_MARK]) state <= tlms_pkg::S_WAIT;
          else if (rec_insert) state <= tlms_pkg::S_CLRQ;
          else if (rec_check) state <= tlms_pkg::S_CHECK;
          else state <= tlms_pkg::S_WRITE;
        end
        tlms_pkg::S_CHECK: begin
          state <= chk_zero ? tlms_pkg::S_CLRQ
                            : tlms_pkg::S_HALT;
        end
        tlms_pkg::S_WRITE: begin
          // load mode and repeated input go round again
          state <= (ctrl_load || rpt) ? tlms_pkg::S_CLRQ
                                      : tlms_pkg::S_IDLE;
        end
        tlms_pkg::S_HALT: begin
          if (start_cmd) state <= tlms_pkg::S_CLRQ;
        end
      endcase
    end
  end

  // input register and resume flag; a new resume beats the consume
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_reg <= 7'h00;
      ir     <= 1'b0;
    end else begin
      if (resume_edge && (!ir || step)) begin
        in_reg <= frame_s;
      end else if (load_edge) begin
        in_reg <= 7'h00;
      end
      ir <= resume_edge || (ir && !step && !load_edge);
    end
  end

  // fault flags, cleared when a new operation starts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_fault  <= 1'b0;
      chk_fault <= 1'b0;
    end else if (load_edge || start_cmd) begin
      in_fault  <= 1'b0;
      chk_fault <= 1'b0;
    end else begin
      if (dbl_resume) in_fault <= 1'b1;
      if (state == tlms_pkg::S_CHECK && !chk_zero) begin
        chk_fault <= 1'b1;
      end
    end
  end

  // input enable, transfer flag and truncated final enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ie      <= 1'b0;
      itx     <= 1'b0;
      fin_cnt <= 9'h000;
    end else if (load_exit || (disc_edge && active) || dbl_resume) begin
      ie      <= 1'b0;
      itx     <= 1'b0;
      fin_cnt <= 9'h000;
    end else if (state == tlms_pkg::S_CLRQ) begin
      ie      <= 1'b1;
      itx     <= 1'b1;
      fin_cnt <= 9'h000;
    end else if (step) begin
      itx <= 1'b0;
    end else if (state == tlms_pkg::S_ACT) begin
      if (!seq[`C_MARK]) begin
        itx <= 1'b1;
      end else if (ctrl_load) begin
        ie <= 1'b0;
      end else if (!rpt) begin
        fin_cnt <= 9'(FIN);
      end
    end else if (fin_cnt != 9'h000) begin
      fin_cnt <= fin_cnt - 9'h001;
      if (fin_cnt == 9'h001) ie <= 1'b0;
    end
  end

  // exchange, assembly, accumulator and address registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xch    <= 24'h000000;
      asm_q  <= 24'h000000;
      acc    <= 24'h000000;
      addr_u <= 15'h0000;
      prog_p <= 15'h0000;
    end else if (load_edge) begin
      xch    <= 24'h000000;
      asm_q  <= 24'h000000;
      acc    <= 24'h000000;
      addr_u <= 15'h0000;
      prog_p <= 15'h0000;
    end else begin
      if (state == tlms_pkg::S_CLRQ) begin
        asm_q <= 24'h000000;
      end
      if (step) begin
        xch   <= {17'h00000, in_reg};
        asm_q <= {asm_q[17:0], in_reg[5:0]};
      end
      if (act_rec) begin
        xch <= asm_q;
      end
      if (rec_insert) begin
        addr_u <= asm_q[14:0];
      end
      if (rec_check) begin
        acc <= asm_q;
      end
      if (state == tlms_pkg::S_CHECK) begin
        acc <= acc - {9'h000, addr_u};
        if (chk_zero) prog_p <= prog_p + 15'h0001;
      end
      if (state == tlms_pkg::S_WRITE && ctrl_load) begin
        addr_u <= addr_u + 15'h0001;
      end
      if (bus_we && hit(avs_address, `REG_ADDR) && !active) begin
        addr_u <= avs_writedata[14:0];
      end
    end
  end

  // storage write port and next-instruction pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req    <= '0;
      next_instr <= 1'b0;
    end else begin
      mem_req.we    <= (state == tlms_pkg::S_WRITE);
      mem_req.low15 <= !ctrl_load && (m_sel == `M_LOW15);
      mem_req.addr  <= addr_u;
      mem_req.data  <= xch;
      next_instr    <= disc_edge && active;
    end
  end

  assign input_enable = ie;

  // read data selection; unmapped offsets read zero
  always_comb begin
    tlms_pkg::status_t st;
    st = '{load_active: ctrl_load, seq: seq, resume_flag: ir,
           itx_flag: itx, enable_flag: ie, check_fault: chk_fault,
           input_fault: in_fault, state: state};
    rd_mux = 32'h00000000;
    if (hit(avs_address, `REG_CTRL)) begin
      rd_mux = {26'h0000000, rpt, m_sel, 1'b0, ctrl_load};
    end else if (hit(avs_address, `REG_STATUS)) begin
      rd_mux = {18'h00000, st};
    end else if (hit(avs_address, `REG_ADDR)) begin
      rd_mux = {17'h00000, addr_u};
    end else if (hit(avs_address, `REG_PADDR)) begin
      rd_mux = {17'h00000, prog_p};
    end else if (hit(avs_address, `REG_ACC)) begin
      rd_mux = {8'h00, acc};
    end else if (hit(avs_address, `REG_WORD)) begin
      rd_mux = {8'h00, xch};
    end
  end

  // avalon handshake: one wait cycle, then one answer cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
    end
  end

  // checks
  a_final_en_len: assert property (@(posedge clk) disable iff (sys_rst)
    (fin_cnt == 9'h001) |=> !input_enable)
    else $error("final enable not dropped at end of countdown");
  a_final_en_arm: assert property (@(posedge clk) disable iff (sys_rst)
    (act_rec && !ctrl_load && !rpt && !disc_edge && !dbl_resume)
    |=> (fin_cnt == 9'(FIN)) && input_enable)
    else $error("final enable countdown not armed");
  a_store_word: assert property (@(posedge clk) disable iff (sys_rst)
    (state == tlms_pkg::S_WRITE) |=> mem_req.we
    && mem_req.data == $past(xch) && mem_req.addr == $past(addr_u))
    else $error("assembled word not written");
  a_load_clear: assert property (@(posedge clk) disable iff (sys_rst)
    load_edge |=> state == tlms_pkg::S_CLRQ ##1 input_enable && itx
    && asm_q == 24'h000000)
    else $error("load mode entry did not clear and request");
  a_resume_take: assert property (@(posedge clk) disable iff (sys_rst)
    (resume_edge && !ir) |=> ir && in_reg == $past(frame_s))
    else $error("resume did not load input register");
  a_frame_pack: assert property (@(posedge clk) disable iff (sys_rst)
    (step && !load_edge) |=> asm_q[5:0] == $past(in_reg[5:0])
    && asm_q[23:6] == $past(asm_q[17:0]) && seq[4:1] == $past(seq[3:0]))
    else $error("frame step did not pack and shift");
  a_insert_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (rec_insert && !load_exit && !disc_edge && !dbl_resume)
    |=> addr_u == $past(asm_q[14:0]) && state == tlms_pkg::S_CLRQ)
    else $error("insert record did not load address");
  a_enable_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (act_rec && ctrl_load) |=> !input_enable)
    else $error("enable still high after fourth frame");
  a_check_fault: assert property (@(posedge clk) disable iff (sys_rst)
    (state == tlms_pkg::S_CHECK && !chk_zero && !load_edge && !load_exit)
    |=> chk_fault && state == tlms_pkg::S_HALT)
    else $error("address mismatch did not halt");
  a_enter_adv: assert property (@(posedge clk) disable iff (sys_rst)
    (state == tlms_pkg::S_WRITE && ctrl_load && !load_edge)
    |=> addr_u == $past(addr_u) + 15'h0001)
    else $error("address not advanced after data record");
  a_disc_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (disc_edge && active && !load_edge) |=> !itx && !rpt && next_instr
    && state == tlms_pkg::S_IDLE)
    else $error("disconnect did not clear and fetch");
  a_double_res: assert property (@(posedge clk) disable iff (sys_rst)
    (dbl_resume && !load_edge && !load_exit) |=> in_fault
    && state == tlms_pkg::S_HALT)
    else $error("double resume not faulted");
  a_hold_wait: assert property (@(posedge clk) disable iff (sys_rst)
    (state == tlms_pkg::S_WAIT && !ir && !load_edge) |=> $stable(asm_q))
    else $error("assembly moved without a frame");

  c_insert: cover property (@(posedge clk) disable iff (sys_rst) rec_insert);
  c_check:  cover property (@(posedge clk) disable iff (sys_rst)
    state == tlms_pkg::S_CHECK && chk_zero);
  c_data:   cover property (@(posedge clk) disable iff (sys_rst)
    mem_req.we && ctrl_load);
  c_final:  cover property (@(posedge clk) disable iff (sys_rst)
    fin_cnt == 9'h001);
endmodule : tape_load_mode_sequencer

// ---- verilog/tlms_consts.svh ----
// offsets, control fields, sequence stages and timing for the tape loader
// How it works
// - non-repeated input cuts final enable to 12 us
// - full word goes to exchange, written; m=4 low 15
// - load switch clears all, clear-assembly requests frame
// - resume loads frame into input register, sets flag
// - control level classifies insert, check or data record
// - per frame: exchange, shift sequence, pack six bits
// - insert record loads low 15 bits as address
// - fourth frame withdraws input enable before acting
// - check record subtracts address; zero advances, else halt
// - data record writes word, then advances address
// - five stage sequence register, left and end-around
// - lowest stage shifts up, takes control level loading
// - stage a feeds end marker; preset loads, clears it
// - disconnect clears transfer and repeat, fetches next
// - second resume before sampling sets input fault, halts
// - modes 0 and 4 pack four six-bit characters
`ifndef TLMS_CONSTS_SVH
`define TLMS_CONSTS_SVH

// register byte offsets
`define REG_CTRL    8'h00
`define REG_STATUS  8'h04
`define REG_ADDR    8'h08
`define REG_PADDR   8'h0C
`define REG_ACC     8'h10
`define REG_WORD    8'h14

// control register fields
`define CTRL_LOAD_BIT   0
`define CTRL_START_BIT  1
`define CTRL_M_LSB      2
`define CTRL_M_MSB      4
`define CTRL_RPT_BIT    5

// word-assembly selector values
`define M_FULL      3'h0
`define M_LOW15     3'h4

// sequence register stage indices: end marker, a, b, c, d
`define C_MARK      4
`define C_A         3
`define C_B         2
`define C_C         1
`define C_D         0
`define C_PRESET    5'h11
`define C_RESET     5'h00

// timing: clock period and truncated final enable pulse
`define CLK_PERIOD_NS    25
`define T_FINAL_EN_NS    12000
`define FINAL_EN_CYCLES  (`T_FINAL_EN_NS / `CLK_PERIOD_NS)

`endif

// ---- verilog/tlms_pkg.sv ----
// types shared by the tape loader modules
package tlms_pkg;

  // sequencer states, gray coded in the order listed
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_CLRQ  = 3'h1,
    S_WAIT  = 3'h3,
    S_STEP  = 3'h2,
    S_ACT   = 3'h6,
    S_CHECK = 3'h7,
    S_WRITE = 3'h5,
    S_HALT  = 3'h4
  } state_t;

  // one storage write request
  typedef struct packed {
    logic        we;     // one-cycle write strobe
    logic        low15;  // store only the low fifteen bits
    logic [14:0] addr;   // storage address
    logic [23:0] data;   // word to store
  } mem_req_t;

  // status register image, high bits first from the left
  typedef struct packed {
    logic       load_active;
    logic [4:0] seq;
    logic       resume_flag;
    logic       itx_flag;
    logic       enable_flag;
    logic       check_fault;
    logic       input_fault;
    logic [2:0] state;
  } status_t;

endpackage : tlms_pkg

// ---- verilog/tlms_sync3.sv ----
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module tlms_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] clean
);
  logic [W-1:0] s1;  // metastability catcher, read only by s2
  logic [W-1:0] s2;  // second stage
  logic [W-1:0] s3;  // third stage

  // shift chain
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit: accept a new level only when two stages agree
  for (genvar k = 0; k < W; k++) begin : g_agree
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        clean[k] <= 1'b0;
      end else if (s2[k] == s3[k]) begin
        clean[k] <= s3[k];
      end
    end
  end
endmodule : tlms_sync3

// ---- verilog/tlms_seq_reg.sv ----
// five-stage word sequence register with left and end-around shift
`timescale 1ns/10ps
`include "tlms_consts.svh"
module tlms_seq_reg (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clr_all,    // load switch: clear everything
  input  wire logic       preset,     // set end marker and d
  input  wire logic       clr_marker, // record done: keep only d
  input  wire logic       shift,      // one frame step
  input  wire logic       load_mode,  // d from control level, else a
  input  wire logic       ctrl_bit,   // control level of the frame
  output logic      [4:0] seq
);
  // stage update; clear beats preset beats shift
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq <= `C_RESET;
    end else if (clr_all) begin
      seq <= `C_RESET;
    end else if (preset) begin
      seq <= `C_PRESET;
    end else if (clr_marker) begin
      seq <= {4'h0, seq[`C_D]};
    end else if (shift) begin
      // a into marker, each stage up one; d from tape or end-around
      seq <= {seq[3:0], load_mode ? ctrl_bit : seq[`C_A]};
    end
  end
endmodule : tlms_seq_reg

// ---- bench/tape_reader.sv ----
// paper tape reader model answering enable with frames
`timescale 1ns/10ps
module tape_reader #(
  parameter int GUARD = 500
) (
  input  wire logic       clk,
  input  wire logic       input_enable,
  output logic      [6:0] frame_in,
  output logic            input_resume
);
  logic [6:0] q[$]; // frames still on tape
  int         on;   // cycles enable has stood high
  // short enable pulses never start a read
  always @(posedge clk) on <= input_enable ? on + 1 : 0;
  // one frame per pass while enable stays long high, resume after data settles
  initial begin
    frame_in = 7'h00;
    input_resume = 1'b0;
    forever begin
      @(posedge clk);
      if (on > GUARD && q.size() > 0) begin
        frame_in <= q.pop_front();
        repeat (2) @(posedge clk);
        input_resume <= 1'b1;
        repeat (8) @(posedge clk);
        input_resume <= 1'b0;
        repeat (8) @(posedge clk);
        frame_in <= ~frame_in; // lines released
      end
    end
  end
endmodule : tape_reader

// ---- bench/tape_load_mode_sequencer_tb.sv ----
// self-checking bench for the tape load sequencer
`timescale 1ns/10ps
module tape_load_mode_sequencer_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic ext_disconnect = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv;
  logic avs_waitrequest, input_enable, input_resume, next_instr;
  logic [6:0] frame_in;
  tlms_pkg::mem_req_t mem_req;
  int err_total = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  tape_load_mode_sequencer uut (.clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .frame_in, .input_resume, .ext_disconnect,
    .input_enable, .mem_req, .next_instr);
  tape_reader rdr (.clk, .input_enable, .frame_in, .input_resume);
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest samples low
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rv, e);
  endtask : rdchk
  // four frames, first lands in the top six bits
  task automatic push(logic [3:0] c, logic [23:0] w);
    for (int i = 0; i < 4; i++)
      rdr.q.push_back({c[3-i], w[23-6*i -: 6]});
  endtask : push
  task automatic wait_we();
    int n = 0;
    while (mem_req.we !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("we_pulse", mem_req.we, 1);
  endtask : wait_we
  task automatic wait_idle();
    while (rdr.q.size() > 0) @(posedge clk);
    repeat (80) @(posedge clk);
  endtask : wait_idle
  task automatic t_reset();
    chk("waitreq", avs_waitrequest, 1);
    rdchk("status", 8'h04, 32'h0);
    rdchk("unmapped", 8'h18, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_load();
    bus(1'b1, 8'h00, 32'h1);
    repeat (4) @(posedge clk);
    chk("enable", input_enable, 1);
    rdr.q.push_back(7'h40);
    push(4'h9, 24'hABC123);
    push(4'h1, 24'hA5C3E7);
    wait_we();
    chk("en_drop", input_enable, 0);
    chk("addr", mem_req.addr, 15'h4123);
    chk("data", mem_req.data, 24'hA5C3E7);
    rdchk("u_next", 8'h08, 32'h4124);
    push(4'h5, 24'h004124);
    wait_idle();
    rdchk("paddr", 8'h0C, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk("seq", rv[12:8], 5'h01);
    push(4'h5, 24'h000777);
    wait_idle();
    bus(1'b0, 8'h04, 32'h0);
    chk("fault", rv[4:0], 5'h14);
    $display("load test done");
  endtask : t_load
  task automatic t_disc();
    int n = 0;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    repeat (4) @(posedge clk);
    ext_disconnect <= 1'b1;
    while (next_instr !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("next", next_instr, 1);
    chk("en_off", input_enable, 0);
    ext_disconnect <= 1'b0;
    bus(1'b0, 8'h04, 32'h0);
    chk("itx", {rv[6], rv[4], rv[2:0]}, 5'h00);
    // repeated word input: enable stays up, disconnect drops repeat
    bus(1'b1, 8'h00, 32'h0);
    push(4'h0, 24'h123456);
    bus(1'b1, 8'h00, 32'h22);
    wait_we();
    chk("r_data", mem_req.data, 24'h123456);
    repeat (600) @(posedge clk);
    chk("r_en", input_enable, 1);
    n = 0;
    ext_disconnect <= 1'b1;
    while (next_instr !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("r_next", next_instr, 1);
    ext_disconnect <= 1'b0;
    rdchk("r_ctrl", 8'h00, 32'h0);
    $display("disconnect test done");
  endtask : t_disc
  task automatic t_input(logic [2:0] m);
    int n = 0;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h08, 32'h55);
    push(4'h0, 24'h3C5A69);
    bus(1'b1, 8'h00, {27'h0, m, 2'h2});
    wait_we();
    chk("low15", mem_req.low15, m == 3'h4);
    chk("m_addr", mem_req.addr, 15'h55);
    chk("m_data", mem_req.data, 24'h3C5A69);
    while (input_enable === 1'b1 && n < 900) begin
      @(posedge clk);
      n++;
    end
    chk("en_len", n > 470 && n < 490, 1);
    $display("input test done");
  endtask : t_input
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_load();
    t_disc();
    t_input(3'h0);
    t_input(3'h4);
    test_done();
  end
  // watchdog well past the expected run length
  initial begin
    #500000;
    err_total++;
    test_done();
  end
endmodule : tape_load_mode_sequencer_tb
